// ===== cef_pkg.sv
// ==========================================================================
// Shared constants for the charger event flag bank.
// ==========================================================================
package cef_pkg;

  // ========================================================================
  // Register offsets on the internal register access port.
  // ========================================================================
  localparam logic [7:0] CEF_OFS_FLAGS_A = 8'h23;
  localparam logic [7:0] CEF_OFS_FLAGS_B = 8'h24;
  localparam logic [7:0] CEF_OFS_FLAGS_C = 8'h25;

  // Value of every flag register after power-on reset.
  localparam logic [7:0] CEF_FLAGS_RESET = 8'h00;
  // Value returned for a read of an address outside the bank.
  localparam logic [7:0] CEF_UNMAPPED_DATA = 8'h00;

  // Bits that exist in each register; all other bits read zero.
  localparam logic [7:0] CEF_VALID_A = 8'hd7;
  localparam logic [7:0] CEF_VALID_B = 8'h7f;
  localparam logic [7:0] CEF_VALID_C = 8'h1f;

  // ========================================================================
  // Field positions, first register.
  // ========================================================================
  localparam int CEF_A_CHARGE_STATE = 7;
  localparam int CEF_A_ICO_CHANGE = 6;
  localparam int CEF_A_SUPPLY_CHANGE = 4;
  localparam int CEF_A_THERMAL_REG = 2;
  localparam int CEF_A_BATT_PRESENT = 1;
  localparam int CEF_A_PORT_DETECT = 0;

  // Field positions, second register.
  localparam int CEF_B_DATA_LINE_DONE = 6;
  localparam int CEF_B_ADC_DONE = 5;
  localparam int CEF_B_MIN_SYS_REG = 4;
  localparam int CEF_B_FAST_TIMEOUT = 3;
  localparam int CEF_B_TRICKLE_TIMEOUT = 2;
  localparam int CEF_B_PRECHARGE_TIMEOUT = 1;
  localparam int CEF_B_TOPOFF_TIMEOUT = 0;

  // Field positions, third register.
  localparam int CEF_C_BATT_LOW_OUTPUT = 4;
  localparam int CEF_C_THERM_COLD = 3;
  localparam int CEF_C_THERM_COOL = 2;
  localparam int CEF_C_THERM_WARM = 1;
  localparam int CEF_C_THERM_HOT = 0;

  // ========================================================================
  // Single-bit event sources and their edge mode.
  // ========================================================================
  localparam int CEF_NUM_SGL = 14;
  localparam int CEF_SRC_TREG = 0;
  localparam int CEF_SRC_BATT_PRES = 1;
  localparam int CEF_SRC_DL_DONE = 2;
  localparam int CEF_SRC_ADC_DONE = 3;
  localparam int CEF_SRC_MIN_SYS = 4;
  localparam int CEF_SRC_FAST_TMR = 5;
  localparam int CEF_SRC_TRICKLE_TMR = 6;
  localparam int CEF_SRC_PRE_TMR = 7;
  localparam int CEF_SRC_TOPOFF_TMR = 8;
  localparam int CEF_SRC_BATT_LOW = 9;
  localparam int CEF_SRC_COLD = 10;
  localparam int CEF_SRC_COOL = 11;
  localparam int CEF_SRC_WARM = 12;
  localparam int CEF_SRC_HOT = 13;
  // A one marks a source that raises its flag on a rising edge only.
  localparam logic [13:0] CEF_SGL_RISE_ONLY = 14'h03ed;

  // Number of flag registers in the bank.
  localparam int CEF_NUM_REGS = 3;

endpackage

// ===== cef_event_detect.sv
`timescale 1ns/1ps
// ==========================================================================
// Synchronises an asynchronous level and detects its change or rising edge.
// ==========================================================================
module cef_event_detect #(
  parameter int W = 1,
  parameter bit RISE_ONLY = 1'b0
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Asynchronous level from the analog side.
  input wire logic [W-1:0] level_i,
  // One-cycle event.
  output logic event_o
);

  // Refuse a width that leaves nothing to watch.
  if (W < 1) begin : g_bad_width
    $error("cef_event_detect needs a width of at least one");
  end

  logic [W-1:0] sync1_q;  // First stage; read only by the second stage.
  logic [W-1:0] sync2_q;  // Second stage; the first safe copy.
  logic [W-1:0] prev_q;   // Previous safe copy, for edge detection.
  logic [2:0] fill_q;     // Ones shift in until both copies hold real samples.
  logic [2:0] fill_d;

  // The fill chain keeps a level that is already high at reset from
  // posing as a change.
  always_comb begin
    fill_d = {fill_q[1:0], 1'b1};
  end

  // Registers of the synchroniser, the history and the fill chain.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
      fill_q <= 3'h0;
    end else begin
      sync1_q <= level_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      fill_q <= fill_d;
    end
  end

  // Rising-edge sources fire on a low-to-high step; others on any change.
  always_comb begin
    if (RISE_ONLY) begin
      event_o = fill_q[2] & (|(sync2_q & ~prev_q));
    end else begin
      event_o = fill_q[2] & (sync2_q != prev_q);
    end
  end

  // A rising-edge event must follow a low-to-high step at the pin, seen through
  // the two synchroniser stages, so a broken chain or history flop shows up here.
  rise_only_high_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (RISE_ONLY && event_o) |-> (($past(level_i, 2) & ~$past(level_i, 3)) != '0))
    else $error("rising-edge event without a rising level");

endmodule

// ===== cef_flag_bank.sv
`timescale 1ns/1ps
// Operation
// - All three flag registers clear at reset.
// - Bit 7 first register: charge status changed.
// - Bit 6 first register: optimizer status changed.
// - Bit 4 first: supply changed; 5,3 read zero.
// - Bit 2 first: thermal regulation rising edge.
// - Bit 1 first: battery presence changed.
// - Bit 0 first: port detection status changed.
// - Bit 6 second: data-line detection completed.
// - Bit 5 second: ADC done, single-conversion only.
// - Bit 4 second: enter or leave minimum regulation.
// - Bit 3 second: fast-charge timer expiry rising.
// - Bit 2 second: trickle timer expiry rising.
// - Bit 1 second: precharge expiry; bit 7 zero.
// - Bit 0 second: top-off timer expiry rising.
// - Bit 4 third: battery too low; 7-5 zero.
// - Bit 3 third: thermistor crossed cold point.
// - Bit 2 third: thermistor crossed cool point.
// - Bit 1 third: thermistor crossed warm point.
// - Bit 0 third: thermistor crossed hot point.
// - Unmasked events pulse interrupt; masked ones do not.
module cef_flag_bank
  import cef_pkg::*;
#(
  parameter int CHG_W = 3,
  parameter int ICO_W = 2,
  parameter int SUPPLY_W = 4,
  parameter int PORT_W = 4
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Internal register access port from the serial interface, same clock.
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Multi-bit status levels from the charger core, asynchronous.
  input wire logic [CHG_W-1:0] charge_status_i,
  input wire logic [ICO_W-1:0] ico_status_i,
  input wire logic [SUPPLY_W-1:0] supply_status_i,
  input wire logic [PORT_W-1:0] port_detect_status_i,
  // Single-bit condition levels from the charger core, asynchronous.
  input wire logic thermal_reg_i,
  input wire logic battery_present_i,
  input wire logic data_line_done_i,
  input wire logic adc_done_i,
  input wire logic min_sys_reg_i,
  input wire logic fast_timer_expired_i,
  input wire logic trickle_timer_expired_i,
  input wire logic precharge_timer_expired_i,
  input wire logic topoff_timer_expired_i,
  input wire logic battery_low_output_i,
  input wire logic therm_cold_i,
  input wire logic therm_cool_i,
  input wire logic therm_warm_i,
  input wire logic therm_hot_i,
  // Configuration from neighbouring registers, same clock.
  input wire logic adc_one_shot_i,
  input wire logic [7:0] mask_a_i,
  input wire logic [7:0] mask_b_i,
  input wire logic [7:0] mask_c_i,
  // Interrupt pulse toward the interrupt pin driver.
  output logic int_pulse_o
);

  // All assertions of this module run on the one system clock.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // ========================================================================
  // Elaboration checks.
  // ========================================================================
  if (CHG_W < 1 || ICO_W < 1 || SUPPLY_W < 1 || PORT_W < 1) begin : g_bad_width
    $error("cef_flag_bank status widths must be at least one");
  end

  // ========================================================================
  // Decoding helpers.
  // ========================================================================

  // Returns one when the address falls on a flag register.
  function automatic logic addr_hit(input logic [7:0] addr);
    begin
      addr_hit = (addr == CEF_OFS_FLAGS_A) || (addr == CEF_OFS_FLAGS_B) ||
                 (addr == CEF_OFS_FLAGS_C);
    end
  endfunction

  // Returns the array index of a flag register address.
  function automatic logic [1:0] addr_index(input logic [7:0] addr);
    begin
      if (addr == CEF_OFS_FLAGS_B) begin
        addr_index = 2'h1;
      end else if (addr == CEF_OFS_FLAGS_C) begin
        addr_index = 2'h2;
      end else begin
        addr_index = 2'h0;
      end
    end
  endfunction

  // Returns the bits that exist in a flag register.
  function automatic logic [7:0] valid_bits(input int idx);
    begin
      if (idx == 1) begin
        valid_bits = CEF_VALID_B;
      end else if (idx == 2) begin
        valid_bits = CEF_VALID_C;
      end else begin
        valid_bits = CEF_VALID_A;
      end
    end
  endfunction

  // ========================================================================
  // Event detection.
  // ========================================================================
  logic ev_charge;                   // Charge status changed.
  logic ev_ico;                      // Optimizer status changed.
  logic ev_supply;                   // Supply status changed.
  logic ev_port;                     // Port detection status changed.
  logic [CEF_NUM_SGL-1:0] sgl_level; // Single-bit sources, gathered.
  logic [CEF_NUM_SGL-1:0] sgl_ev;    // Events of the single-bit sources.
  logic [7:0] ev [CEF_NUM_REGS];     // Events placed at their flag bits.
  logic [7:0] mask [CEF_NUM_REGS];   // Interrupt masks, by register.

  // Multi-bit status sources fire on any change of their code.
  cef_event_detect #(.W(CHG_W), .RISE_ONLY(1'b0)) u_det_charge (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .level_i(charge_status_i), .event_o(ev_charge));
  cef_event_detect #(.W(ICO_W), .RISE_ONLY(1'b0)) u_det_ico (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .level_i(ico_status_i), .event_o(ev_ico));
  cef_event_detect #(.W(SUPPLY_W), .RISE_ONLY(1'b0)) u_det_supply (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .level_i(supply_status_i), .event_o(ev_supply));
  cef_event_detect #(.W(PORT_W), .RISE_ONLY(1'b0)) u_det_port (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .level_i(port_detect_status_i), .event_o(ev_port));

  // Gathers the single-bit sources in package index order.
  always_comb begin
    sgl_level = '0;
    sgl_level[CEF_SRC_TREG] = thermal_reg_i;
    sgl_level[CEF_SRC_BATT_PRES] = battery_present_i;
    sgl_level[CEF_SRC_DL_DONE] = data_line_done_i;
    sgl_level[CEF_SRC_ADC_DONE] = adc_done_i;
    sgl_level[CEF_SRC_MIN_SYS] = min_sys_reg_i;
    sgl_level[CEF_SRC_FAST_TMR] = fast_timer_expired_i;
    sgl_level[CEF_SRC_TRICKLE_TMR] = trickle_timer_expired_i;
    sgl_level[CEF_SRC_PRE_TMR] = precharge_timer_expired_i;
    sgl_level[CEF_SRC_TOPOFF_TMR] = topoff_timer_expired_i;
    sgl_level[CEF_SRC_BATT_LOW] = battery_low_output_i;
    sgl_level[CEF_SRC_COLD] = therm_cold_i;
    sgl_level[CEF_SRC_COOL] = therm_cool_i;
    sgl_level[CEF_SRC_WARM] = therm_warm_i;
    sgl_level[CEF_SRC_HOT] = therm_hot_i;
  end

  // One detector per single-bit source; the package picks its edge mode.
  for (genvar g = 0; g < CEF_NUM_SGL; g++) begin : g_sgl
    cef_event_detect #(.W(1), .RISE_ONLY(CEF_SGL_RISE_ONLY[g])) u_det (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .level_i(sgl_level[g]), .event_o(sgl_ev[g]));
  end

  // Places each event at its flag bit; reserved bits never see an event.
  always_comb begin
    ev[0] = 8'h00;
    ev[1] = 8'h00;
    ev[2] = 8'h00;
    ev[0][CEF_A_CHARGE_STATE] = ev_charge;
    ev[0][CEF_A_ICO_CHANGE] = ev_ico;
    ev[0][CEF_A_SUPPLY_CHANGE] = ev_supply;
    ev[0][CEF_A_THERMAL_REG] = sgl_ev[CEF_SRC_TREG];
    ev[0][CEF_A_BATT_PRESENT] = sgl_ev[CEF_SRC_BATT_PRES];
    ev[0][CEF_A_PORT_DETECT] = ev_port;
    ev[1][CEF_B_DATA_LINE_DONE] = sgl_ev[CEF_SRC_DL_DONE];
    ev[1][CEF_B_ADC_DONE] = sgl_ev[CEF_SRC_ADC_DONE] & adc_one_shot_i;
    ev[1][CEF_B_MIN_SYS_REG] = sgl_ev[CEF_SRC_MIN_SYS];
    ev[1][CEF_B_FAST_TIMEOUT] = sgl_ev[CEF_SRC_FAST_TMR];
    ev[1][CEF_B_TRICKLE_TIMEOUT] = sgl_ev[CEF_SRC_TRICKLE_TMR];
    ev[1][CEF_B_PRECHARGE_TIMEOUT] = sgl_ev[CEF_SRC_PRE_TMR];
    ev[1][CEF_B_TOPOFF_TIMEOUT] = sgl_ev[CEF_SRC_TOPOFF_TMR];
    ev[2][CEF_C_BATT_LOW_OUTPUT] = sgl_ev[CEF_SRC_BATT_LOW];
    ev[2][CEF_C_THERM_COLD] = sgl_ev[CEF_SRC_COLD];
    ev[2][CEF_C_THERM_COOL] = sgl_ev[CEF_SRC_COOL];
    ev[2][CEF_C_THERM_WARM] = sgl_ev[CEF_SRC_WARM];
    ev[2][CEF_C_THERM_HOT] = sgl_ev[CEF_SRC_HOT];
    mask[0] = mask_a_i;
    mask[1] = mask_b_i;
    mask[2] = mask_c_i;
  end

  // ========================================================================
  // Flag registers, read port and interrupt pulse.
  // ========================================================================
  logic [7:0] flags_q [CEF_NUM_REGS]; // Sticky flags.
  logic [7:0] flags_d [CEF_NUM_REGS];
  logic [7:0] rdata_q;                // Registered read data.
  logic [7:0] rdata_d;
  logic rvalid_q;                     // Read answer strobe.
  logic rvalid_d;
  logic int_q;                        // Interrupt pulse.
  logic int_d;
  logic rd_hit;                       // A read lands on a flag register.
  logic [1:0] rd_idx;                 // Which flag register is read.
  logic any_unmasked;                 // Some unmasked event this cycle.

  // Next values of the flags, the read answer and the interrupt.
  always_comb begin
    rd_hit = reg_rd_i && addr_hit(reg_addr_i);
    rd_idx = addr_index(reg_addr_i);
    any_unmasked = 1'b0;
    for (int i = 0; i < CEF_NUM_REGS; i++) begin
      flags_d[i] = flags_q[i];
      if (rd_hit && (rd_idx == i[1:0])) begin
        flags_d[i] = CEF_FLAGS_RESET;
      end
      flags_d[i] = (flags_d[i] | ev[i]) & valid_bits(i);
      any_unmasked = any_unmasked | (|(ev[i] & ~mask[i]));
    end
    // writes ignored
    // Writes are not decoded here at all, so the flags ignore them.
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      if (rd_hit) begin
        rdata_d = flags_q[rd_idx];
      end else begin
        rdata_d = CEF_UNMAPPED_DATA;
      end
    end
    rvalid_d = reg_rd_i;
    int_d = any_unmasked;
  end

  // Registers every piece of state; reset gives the documented zeros.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < CEF_NUM_REGS; i++) begin
        flags_q[i] <= CEF_FLAGS_RESET;
      end
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      for (int i = 0; i < CEF_NUM_REGS; i++) begin
        flags_q[i] <= flags_d[i];
      end
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      int_q <= int_d;
    end
  end

  // Outputs straight from flip-flops.
  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign int_pulse_o = int_q;

  // ========================================================================
  // Assertions.
  // ========================================================================
  logic rd_a;  // A read of the first flag register.
  assign rd_a = rd_hit && (rd_idx == 2'h0);

  reset_clear_a: assert property ($past(sys_rst_i) |->
    (flags_q[0] == 8'h00 && flags_q[1] == 8'h00 && flags_q[2] == 8'h00))
    else $error("flags not clear after reset");
  reserved_zero_a: assert property (((flags_q[0] & ~CEF_VALID_A) == 8'h00) &&
    ((flags_q[1] & ~CEF_VALID_B) == 8'h00) && ((flags_q[2] & ~CEF_VALID_C) == 8'h00))
    else $error("reserved flag bit set");
  charge_flag_a: assert property (ev_charge |=> flags_q[0][CEF_A_CHARGE_STATE])
    else $error("charge change not flagged");
  adc_gate_a: assert property ((sgl_ev[CEF_SRC_ADC_DONE] && !adc_one_shot_i &&
    !flags_q[1][CEF_B_ADC_DONE] && !(rd_hit && rd_idx == 2'h1)) |=> !flags_q[1][CEF_B_ADC_DONE])
    else $error("ADC done flagged outside one-shot mode");
  cold_flag_a: assert property (sgl_ev[CEF_SRC_COLD] ##1 !rd_hit |->
    ##1 flags_q[2][CEF_C_THERM_COLD])
    else $error("cold crossing lost");
  flag_sticky_a: assert property (!rd_a |=>
    ((flags_q[0] & $past(flags_q[0])) == $past(flags_q[0])))
    else $error("flag dropped without a read");
  read_clear_a: assert property ((rd_a && ev[0] == 8'h00) |=> flags_q[0] == 8'h00)
    else $error("read did not clear flags");
  read_data_a: assert property (rd_a |=>
    (reg_rvalid_o && reg_rdata_o == $past(flags_q[0])))
    else $error("read returned wrong flags");
  write_ignored_a: assert property ((reg_wr_i && !reg_rd_i && ev[0] == 8'h00) |=>
    flags_q[0] == $past(flags_q[0]))
    else $error("write changed flags");
  // Back-to-back event cycles legally stretch the pulse by one cycle each.
  irq_pulse_a: assert property (any_unmasked |=>
    int_pulse_o ##1 (!int_pulse_o || $past(any_unmasked)))
    else $error("unmasked event gave no interrupt pulse");
  irq_masked_a: assert property (!any_unmasked |=> !int_pulse_o)
    else $error("interrupt pulse without unmasked event");

endmodule

// ===== cef_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Host model that reads and writes the bank over its internal access port.
// ==========================================================================
module cef_host_model (
  // Clock.
  input wire logic clock_i,
  // Register access port toward the bank.
  output logic [7:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  // The port idles with both strobes low from time zero.
  initial begin
    reg_addr_o = 8'h00;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end

  // Issues one read strobe and returns the data that comes with the valid pulse.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    int n;
    @(posedge clock_i);
    reg_addr_o <= addr;
    reg_rd_o <= 1'b1;
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    // A released address shows its inverse so a stale value is never reused.
    reg_addr_o <= ~addr;
    #1;
    n = 0;
    while (reg_rvalid_i !== 1'b1 && n < 4) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    data = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hxx;
  endtask

  // Issues one write strobe; the bank gives no answer to writes.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock_i);
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    reg_wr_o <= 1'b1;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~addr;
    reg_wdata_o <= ~data;
  endtask
endmodule

// ===== charger_event_flag_bank_tb.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the charger event flag bank.
// ==========================================================================
module charger_event_flag_bank_tb;
  import cef_pkg::*;
  // Bit position of each source's flag, in source order.
  localparam int BITPOS[18] = '{7, 6, 4, 2, 1, 0, 6, 5, 4, 3, 2, 1, 0, 4, 3, 2, 1, 0};
  // A one marks a source whose falling edge also raises its flag.
  localparam logic [17:0] BOTH_EDGES = 18'h3c137;
  logic clock_i;
  logic sys_rst_i;
  logic [17:0] lv; // Condition levels, one per source.
  logic adc_one_shot_i;
  logic [7:0] mask_a_i;
  logic [7:0] mask_b_i;
  logic [7:0] mask_c_i;
  logic [7:0] reg_addr;
  logic reg_rd;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic int_pulse_o;
  logic [7:0] d;
  int error_cnt = 0;
  int check_count = 0;
  int pulse_cnt = 0;

  // ========================================================================
  // Design and host model.
  // ========================================================================
  cef_flag_bank cef_flag_bank_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr), .reg_rd_i(reg_rd), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
    .charge_status_i({3{lv[0]}}), .ico_status_i({2{lv[1]}}),
    .supply_status_i({4{lv[2]}}), .port_detect_status_i({4{lv[5]}}),
    .thermal_reg_i(lv[3]), .battery_present_i(lv[4]), .data_line_done_i(lv[6]),
    .adc_done_i(lv[7]), .min_sys_reg_i(lv[8]), .fast_timer_expired_i(lv[9]),
    .trickle_timer_expired_i(lv[10]), .precharge_timer_expired_i(lv[11]),
    .topoff_timer_expired_i(lv[12]), .battery_low_output_i(lv[13]),
    .therm_cold_i(lv[14]), .therm_cool_i(lv[15]), .therm_warm_i(lv[16]),
    .therm_hot_i(lv[17]), .adc_one_shot_i(adc_one_shot_i), .mask_a_i(mask_a_i),
    .mask_b_i(mask_b_i), .mask_c_i(mask_c_i), .int_pulse_o(int_pulse_o));

  cef_host_model cef_host_model_inst (.clock_i(clock_i), .reg_addr_o(reg_addr),
    .reg_rd_o(reg_rd), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata),
    .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));

  // 100 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Counts the cycles in which the interrupt pulse is high.
  always @(posedge clock_i) begin
    if (int_pulse_o === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end

  // ========================================================================
  // Helpers.
  // ========================================================================
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Moves one source level, then reads all three registers and the pulse count.
  task automatic run_event(input int i, input logic v, input logic ev, input logic np);
    logic [7:0] expv;
    @(posedge clock_i);
    lv[i] <= v;
    #1;
    pulse_cnt = 0;
    repeat (8) @(posedge clock_i);
    check(8'(pulse_cnt), {7'h00, np});
    for (int r = 0; r < 3; r++) begin
      cef_host_model_inst.read_reg(8'h23 + 8'(r), d);
      expv = (ev && ((i < 6) ? 0 : (i < 13) ? 1 : 2) == r) ? 8'h01 << BITPOS[i] : 8'h00;
      check(d, expv);
      cef_host_model_inst.read_reg(8'h23 + 8'(r), d);
      check(d, 8'h00);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ========================================================================
  // Test sequence.
  // ========================================================================
  initial begin
    sys_rst_i = 1'b1;
    lv = 18'h00000;
    adc_one_shot_i = 1'b1;
    mask_a_i = 8'h00;
    mask_b_i = 8'h00;
    mask_c_i = 8'h00;
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    // Let the detectors prime before any level moves.
    repeat (5) @(posedge clock_i);
    // Three flag registers and one unmapped address read zero.
    for (int a = 0; a < 4; a++) begin
      cef_host_model_inst.read_reg(8'h23 + 8'(a), d);
      check(d, 8'h00);
    end
    // Raise every source, then lower every source; only some edges count.
    for (int i = 0; i < 18; i++) begin
      run_event(i, 1'b1, 1'b1, 1'b1);
    end
    for (int i = 0; i < 18; i++) begin
      run_event(i, 1'b0, BOTH_EDGES[i], BOTH_EDGES[i]);
    end
    // Conversion done is ignored outside single-conversion mode.
    adc_one_shot_i <= 1'b0;
    run_event(7, 1'b1, 1'b0, 1'b0);
    adc_one_shot_i <= 1'b1;
    // A masked event still sets its flag but gives no pulse.
    mask_a_i <= 8'hff;
    run_event(1, 1'b1, 1'b1, 1'b0);
    mask_a_i <= 8'h00;
    // Writes neither clear a pending flag nor set any bit.
    @(posedge clock_i);
    lv[0] <= 1'b1;
    repeat (8) @(posedge clock_i);
    cef_host_model_inst.write_reg(8'h23, 8'h00);
    cef_host_model_inst.write_reg(8'h24, 8'hff);
    cef_host_model_inst.read_reg(8'h23, d);
    check(d, 8'h80);
    cef_host_model_inst.read_reg(8'h24, d);
    check(d, 8'h00);
    stop_test();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    stop_test();
  end
endmodule
